// ---- rtl/four_mode_serial_port.sv ----
// four-mode serial port with an ahb-lite register slave
// Behaviour
// - transmitter and receiver run independently in modes 1-3; mode 0 reception waits for an idle transmitter
// - receiver assembles while holding byte unread in modes 1-3
// - buffer write sends, buffer read returns received
// - two mode bits select one of four modes
// - mode 0 shifts at clock over twelve
// - mode 0: txd is clock, lsb first
// - mode 0 receive starts: flag clear, enabled
// - mode 2: clock/64, or /32 when doubled
// - modes 1,3: timer overflow pulses set rate
// - receive enable gates all reception
// - modes 2,3 send tx ninth bit
// - rx ninth bit: ninth bit or stop
// - ninth bit one marks address bytes
// - multiprocessor filter drops frames with ninth zero
// - tx done flag set at frame end
// - rx done flag set at frame end
// - enabled flags form one interrupt request
// - software flag writes act like hardware
// - priority bit marks interrupt high or low
// - mode 1 frame: start, eight data, stop
// - modes 2,3 frame adds ninth bit
// - timer selects pick second timer per direction
// - first timer overflow divided 32 or 16
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_consts.svh"
module four_mode_serial_port (
   // clock, reset, freeze
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_enable,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // baud sources from the timers
   input wire serial_port_pkg::baud_src_t baud_src,
   // serial pins
   output logic txd,
   input wire logic rxd_in,
   output logic rxd_out,
   output logic rxd_oe,
   // interrupt request
   output serial_port_pkg::irq_out_t irq
);
   import serial_port_pkg::*;

   localparam logic [3:0] M0_LAST = 4'(`MODE0_DIVIDE - 1);
   localparam logic [3:0] M0_HALF = 4'(`MODE0_DIVIDE / 2);
   localparam logic [1:0] FIX_SLOW_LAST = 2'(`MODE2_SLOW_DIVIDE / `SUBTICKS_PER_BIT - 1);
   localparam logic [1:0] FIX_FAST_LAST = 2'(`MODE2_FAST_DIVIDE / `SUBTICKS_PER_BIT - 1);
   localparam logic [3:0] SUB_LAST = 4'(`SUBTICKS_PER_BIT - 1);
   localparam port_state_t STATE_RESET = '{tx_st: TX_IDLE, rx_st: RX_IDLE, txd: 1'b1, rxd_out: 1'b1,
      rx_prev: 1'b1, default: '0};

   port_state_t st;
   port_state_t next_st;
   mode_t mode;
   logic dbl;
   logic fix_hit;
   logic m0_tick;
   logic tx_tick;
   logic rx_tick;
   logic accept;
   logic wr;
   logic wr_serial_control;
   logic serial_buffer_wr;
   logic [7:0] wd;
   logic [7:0] rd_byte;
   logic set_ti;
   logic set_ri;
   logic rx_finish;
   logic rx_accept;
   logic [8:0] rx_next_shift;
   logic [3:0] rx_last;
   logic [3:0] tx_last;

   // one subtick of an asynchronous bit; mode 2 uses the fixed divider
   function automatic logic async_tick(input mode_t m, input logic fix, input logic sel, input logic pre,
      input logic dbl_in, input baud_src_t b);
      logic ovf;
      ovf = sel ? b.timer2_ovf : b.timer1_ovf;
      if (m == MODE_UART9_FIXED) begin
         async_tick = fix;
      end else if (sel) begin
         async_tick = ovf;
      end else begin
         async_tick = ovf && (dbl_in || pre);
      end
   endfunction

   assign mode = mode_t'(st.serial_control[`SC_MODE_HIGH:`SC_MODE_LOW]);
   assign dbl = st.power_control[`PC_BAUD_DOUBLE];
   assign fix_hit = st.fix_div == (dbl ? FIX_FAST_LAST : FIX_SLOW_LAST);
   assign m0_tick = st.m0_div == M0_LAST;
   // each direction has its own source select, so rates may differ
   assign tx_tick = async_tick(mode, fix_hit, baud_src.tx_timer_select, st.t1_pre, dbl, baud_src);
   assign rx_tick = async_tick(mode, fix_hit, baud_src.rx_timer_select, st.t1_pre, dbl, baud_src);
   assign tx_last = (mode == MODE_UART8) ? `MODE1_LAST_BIT : `MODE9_LAST_BIT;
   assign rx_last = tx_last;
   assign accept = hsel && htrans[1] && hready;
   assign wr = st.ap_valid && st.ap_write && st.ap_map;
   assign wd = hwdata[7:0];
   assign wr_serial_control = wr && (st.ap_index == `IDX_SERIAL_CONTROL);
   assign serial_buffer_wr = wr && (st.ap_index == `IDX_SERIAL_BUFFER);

   always_comb begin
      next_st = st;
      set_ti = 1'b0;
      set_ri = 1'b0;
      rx_finish = 1'b0;
      rx_accept = 1'b0;
      rx_next_shift = st.rx_shift;
      rd_byte = `RESET_BYTE;

      // read mux; reserved and unmapped bits read as zero
      if (!st.ap_map) begin
         rd_byte = `RESET_BYTE;
      end else if (st.ap_index == `IDX_SERIAL_CONTROL) begin
         rd_byte = st.serial_control;
      end else if (st.ap_index == `IDX_SERIAL_BUFFER) begin
         rd_byte = st.rx_hold;
      end else if (st.ap_index == `IDX_POWER_CONTROL) begin
         rd_byte = st.power_control;
      end else if (st.ap_index == `IDX_INTERRUPT_ENABLE) begin
         rd_byte = {3'h0, st.es, 4'h0};
      end else if (st.ap_index == `IDX_INTERRUPT_PRIORITY) begin
         rd_byte = {2'h0, st.ip};
      end

      // bus phases: reads take one wait state so that hrdata comes from a flop
      if (st.rd_wait) begin
         next_st.rd_wait = 1'b0;
         next_st.hrdata = {24'h0, rd_byte};
      end else begin
         next_st.ap_valid = accept;
         next_st.ap_write = hwrite;
         next_st.ap_map = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0);
         next_st.ap_index = haddr[9:2];
         next_st.rd_wait = accept && !hwrite;
      end

      // register writes
      if (wr) begin
         if (st.ap_index == `IDX_SERIAL_CONTROL) begin
            next_st.serial_control = wd;
         end else if (st.ap_index == `IDX_POWER_CONTROL) begin
            next_st.power_control = wd & `POWER_CONTROL_MASK;
         end else if (st.ap_index == `IDX_INTERRUPT_ENABLE) begin
            next_st.es = wd[`IE_SERIAL];
         end else if (st.ap_index == `IDX_INTERRUPT_PRIORITY) begin
            next_st.ip = wd[5:0] & 6'(`PRIORITY_MASK);
         end
      end

      // free-running dividers
      next_st.m0_div = m0_tick ? 4'h0 : st.m0_div + 4'h1;
      next_st.fix_div = fix_hit ? 2'h0 : st.fix_div + 2'h1;
      next_st.t1_pre = st.t1_pre ^ baud_src.timer1_ovf;

      // transmitter, independent of the receiver
      case (st.tx_st)
         TX_IDLE: begin
            next_st.tx_st = TX_IDLE;
         end
         TX_SHIFT: begin
            if (mode == MODE_SHIFT) begin
               next_st.txd = st.m0_div >= M0_HALF;
               if (m0_tick) begin
                  if (st.tx_cnt == `MODE0_BITS - 4'h1) begin
                     next_st.tx_st = TX_IDLE;
                     next_st.txd = 1'b1;
                     set_ti = 1'b1;
                  end else begin
                     next_st.tx_shift = {1'b1, st.tx_shift[10:1]};
                     next_st.rxd_out = st.tx_shift[1];
                     next_st.tx_cnt = st.tx_cnt + 4'h1;
                  end
               end
            end else if (tx_tick) begin
               next_st.tx_sub = st.tx_sub + 4'h1;
               if (st.tx_sub == SUB_LAST) begin
                  if (st.tx_cnt == tx_last) begin
                     next_st.tx_st = TX_IDLE;
                     next_st.txd = 1'b1;
                     set_ti = 1'b1;
                  end else begin
                     next_st.tx_shift = {1'b1, st.tx_shift[10:1]};
                     next_st.txd = st.tx_shift[1];
                     next_st.tx_cnt = st.tx_cnt + 4'h1;
                  end
               end
            end
         end
         default: begin
            next_st.tx_st = TX_IDLE;
         end
      endcase

      // a buffer write starts a frame, restarting one in flight
      if (serial_buffer_wr) begin
         next_st.tx_st = TX_SHIFT;
         next_st.tx_cnt = 4'h0;
         next_st.tx_sub = 4'h0;
         if (mode == MODE_SHIFT) begin
            next_st.tx_shift = {3'h7, wd};
            next_st.rxd_out = wd[0];
            // restart the shift clock so bit 0 always sees a full period with a rising edge
            next_st.m0_div = 4'h0;
         end else begin
            next_st.tx_shift = {1'b1, (mode == MODE_UART8) ? 1'b1 : st.serial_control[`SC_TX_NINTH], wd, 1'b0};
            next_st.txd = 1'b0;
         end
      end

      // receiver
      next_st.rx_prev = rxd_in;
      case (st.rx_st)
         RX_IDLE: begin
            if (mode == MODE_SHIFT) begin
               // txd carries the clock, so a send must not overlap a receive
               if (st.serial_control[`SC_RX_ENABLE] && !st.serial_control[`SC_RX_DONE] && st.tx_st == TX_IDLE && !serial_buffer_wr) begin
                  next_st.rx_st = RX_SHIFT;
                  next_st.rx_cnt = 4'h0;
                  next_st.rx_shift = 9'h0;
                  // same phase restart as a send, so the first bit is not cut short
                  next_st.m0_div = 4'h0;
               end
            end else if (st.serial_control[`SC_RX_ENABLE] && st.rx_prev && !rxd_in) begin
               next_st.rx_st = RX_SHIFT;
               next_st.rx_cnt = 4'h0;
               next_st.rx_sub = 4'h0;
            end
         end
         RX_SHIFT: begin
            if (!st.serial_control[`SC_RX_ENABLE]) begin
               next_st.rx_st = RX_IDLE;
               // only the shift-mode clock belongs to the receiver; an async send keeps its line
               if (mode == MODE_SHIFT) begin
                  next_st.txd = 1'b1;
               end
            end else if (mode == MODE_SHIFT) begin
               next_st.txd = st.m0_div >= M0_HALF;
               if (m0_tick) begin
                  rx_next_shift = {rxd_in, st.rx_shift[8:1]};
                  next_st.rx_shift = rx_next_shift;
                  next_st.rx_cnt = st.rx_cnt + 4'h1;
                  if (st.rx_cnt == `MODE0_BITS - 4'h1) begin
                     next_st.rx_st = RX_IDLE;
                     next_st.txd = 1'b1;
                     next_st.rx_hold = rx_next_shift[8:1];
                     set_ri = 1'b1;
                  end
               end
            end else if (rx_tick) begin
               next_st.rx_sub = st.rx_sub + 4'h1;
               if (st.rx_sub == `SAMPLE_SUBTICK) begin
                  if (st.rx_cnt == 4'h0) begin
                     // a start bit high at its centre was a glitch
                     if (rxd_in) begin
                        next_st.rx_st = RX_IDLE;
                     end else begin
                        next_st.rx_cnt = 4'h1;
                     end
                  end else begin
                     if (st.rx_cnt <= 4'h9) begin
                        rx_next_shift = {rxd_in, st.rx_shift[8:1]};
                     end
                     next_st.rx_shift = rx_next_shift;
                     next_st.rx_cnt = st.rx_cnt + 4'h1;
                     if (st.rx_cnt == rx_last) begin
                        rx_finish = 1'b1;
                        next_st.rx_st = RX_IDLE;
                        // unread byte is kept; a frame ending over it is dropped
                        rx_accept = !st.serial_control[`SC_RX_DONE] &&
                           (!st.serial_control[`SC_MP_ENABLE] || rx_next_shift[8]);
                        if (rx_accept) begin
                           next_st.rx_hold = rx_next_shift[7:0];
                           next_st.serial_control[`SC_RX_NINTH] = rx_next_shift[8];
                           set_ri = 1'b1;
                        end
                     end
                  end
               end
            end
         end
         default: begin
            next_st.rx_st = RX_IDLE;
         end
      endcase

      // hardware set wins over a software clear in the same cycle
      next_st.serial_control[`SC_TX_DONE] = next_st.serial_control[`SC_TX_DONE] | set_ti;
      next_st.serial_control[`SC_RX_DONE] = next_st.serial_control[`SC_RX_DONE] | set_ri;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st <= STATE_RESET;
      end else if (clk_enable) begin
         st <= next_st;
      end
   end

   assign hreadyout = !st.rd_wait;
   assign hresp = 1'b0;
   assign hrdata = st.hrdata;
   assign txd = st.txd;
   assign rxd_out = st.rxd_out;
   assign rxd_oe = (st.tx_st == TX_SHIFT) && (mode == MODE_SHIFT);
   assign irq.request = (st.serial_control[`SC_TX_DONE] | st.serial_control[`SC_RX_DONE]) & st.es;
   assign irq.priority_high = st.ip[`IP_SERIAL];

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn || !clk_enable);

   chk_tx_done_flag: assert property (set_ti |=> st.serial_control[`SC_TX_DONE])
      else $error("tx done flag not set after frame");
   chk_rx_blocked: assert property (!st.serial_control[`SC_RX_ENABLE] |=> st.rx_st == RX_IDLE)
      else $error("receiver active while disabled");
   chk_mode0_rate: assert property (mode == MODE_SHIFT && $rose(txd) |=> (!$rose(txd))[*8])
      else $error("mode 0 shift clock faster than clock over twelve");
   chk_mp_filter: assert property (rx_finish && st.serial_control[`SC_MP_ENABLE] && st.serial_control[`SC_MODE_HIGH] &&
      !rx_next_shift[8] && !st.serial_control[`SC_RX_DONE] && !wr_serial_control |=> !st.serial_control[`SC_RX_DONE])
      else $error("data byte passed the multiprocessor filter");
   chk_tx_ninth: assert property (serial_buffer_wr && st.serial_control[`SC_MODE_HIGH]
      |=> st.tx_shift[9] == $past(st.serial_control[`SC_TX_NINTH]))
      else $error("ninth bit not loaded from tx ninth bit");
   chk_start_bit: assert property (serial_buffer_wr && mode != MODE_SHIFT |=> (!txd)[*8])
      else $error("start bit too short or missing");
   chk_irq_request: assert property (wr_serial_control && wd[`SC_RX_DONE] && st.es |=> irq.request)
      else $error("software set of rx flag did not raise request");
   chk_rx_stop_bit: assert property (rx_finish && rx_accept && mode == MODE_UART8
      |=> st.serial_control[`SC_RX_NINTH] == $past(rxd_in))
      else $error("stop bit not captured in mode 1");
   chk_m0_rx_start: assert property (st.rx_st == RX_IDLE && mode == MODE_SHIFT && st.serial_control[`SC_RX_ENABLE] &&
      !st.serial_control[`SC_RX_DONE] && st.tx_st == TX_IDLE && !serial_buffer_wr |=> st.rx_st == RX_SHIFT)
      else $error("mode 0 reception did not start");

   chk_rx_done_hold: assert property (st.serial_control[`SC_RX_DONE] && !wr_serial_control |=> st.serial_control[`SC_RX_DONE])
      else $error("rx done flag cleared without software");
   chk_tx_done_hold: assert property (st.serial_control[`SC_TX_DONE] && !wr_serial_control |=> st.serial_control[`SC_TX_DONE])
      else $error("tx done flag cleared without software");
   // a frame ending over an unread byte must leave the holding register alone
   chk_rx_hold_kept: assert property (rx_finish && st.serial_control[`SC_RX_DONE] |=> $stable(st.rx_hold))
      else $error("unread byte overwritten");
   chk_mp_address: assert property (rx_finish && st.serial_control[`SC_MP_ENABLE] && st.serial_control[`SC_MODE_HIGH] &&
      rx_next_shift[8] && !st.serial_control[`SC_RX_DONE] |=> st.serial_control[`SC_RX_DONE])
      else $error("address byte did not set rx flag");
   chk_m0_data_out: assert property (serial_buffer_wr && mode == MODE_SHIFT |=> rxd_oe && rxd_out == $past(wd[0]))
      else $error("mode 0 data pin not driven with bit 0");
   chk_rx_ninth_m0: assert property (mode == MODE_SHIFT && !wr_serial_control |=> $stable(st.serial_control[`SC_RX_NINTH]))
      else $error("rx ninth bit changed in mode 0");
   chk_tx_end_idle: assert property (set_ti && !serial_buffer_wr && mode != MODE_SHIFT |=> txd)
      else $error("line not idle after frame");
   chk_rx_start_edge: assert property (st.rx_st == RX_IDLE && mode != MODE_SHIFT &&
      st.serial_control[`SC_RX_ENABLE] && st.rx_prev && !rxd_in |=> st.rx_st == RX_SHIFT)
      else $error("falling edge did not start reception");
   // one wait state keeps read data coming from a flop
   chk_read_wait: assert property (accept && !hwrite && !st.rd_wait |=> !hreadyout ##1 hreadyout)
      else $error("read wait state missing");
endmodule
`default_nettype wire

// ---- include/serial_port_consts.svh ----
// offsets, field positions, reset values and timing counts of the four-mode serial port
`ifndef SERIAL_PORT_CONSTS_SVH
`define SERIAL_PORT_CONSTS_SVH
// register indices; byte address is four times the index
`define IDX_POWER_CONTROL 8'h87
`define IDX_SERIAL_CONTROL 8'h98
`define IDX_SERIAL_BUFFER 8'h99
`define IDX_INTERRUPT_ENABLE 8'hA8
`define IDX_INTERRUPT_PRIORITY 8'hB8
// reset values and writable masks
`define RESET_BYTE 8'h00
`define POWER_CONTROL_MASK 8'hD0
`define PRIORITY_MASK 8'h3F
// serial_control fields
`define SC_RX_DONE 0
`define SC_TX_DONE 1
`define SC_RX_NINTH 2
`define SC_TX_NINTH 3
`define SC_RX_ENABLE 4
`define SC_MP_ENABLE 5
`define SC_MODE_LOW 6
`define SC_MODE_HIGH 7
// other fields
`define PC_BAUD_DOUBLE 7
`define IE_SERIAL 4
`define IP_SERIAL 4
// timing: clock 100 MHz
`define CLK_PERIOD_NS 10
`define MODE0_DIVIDE 12
`define MODE2_SLOW_DIVIDE 64
`define MODE2_FAST_DIVIDE 32
`define SUBTICKS_PER_BIT 16
`define SAMPLE_SUBTICK 4'h7
`define MODE0_BITS 4'h8
`define MODE1_LAST_BIT 4'h9
`define MODE9_LAST_BIT 4'hA
`endif

// ---- include/serial_port_pkg.sv ----
// types shared by the four-mode serial port
package serial_port_pkg;
   typedef enum logic [1:0] {
      MODE_SHIFT = 2'b00,
      MODE_UART8 = 2'b01,
      MODE_UART9_FIXED = 2'b10,
      MODE_UART9_VAR = 2'b11
   } mode_t;
   typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_SHIFT = 2'b01} tx_state_t;
   typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_SHIFT = 2'b01} rx_state_t;
   typedef struct packed {
      logic timer1_ovf;
      logic timer2_ovf;
      logic rx_timer_select;
      logic tx_timer_select;
   } baud_src_t;
   typedef struct packed {
      logic request;
      logic priority_high;
   } irq_out_t;
   typedef struct packed {
      logic [7:0] serial_control;
      logic [7:0] power_control;
      logic es;
      logic [5:0] ip;
      tx_state_t tx_st;
      logic [10:0] tx_shift;
      logic [3:0] tx_cnt;
      logic [3:0] tx_sub;
      rx_state_t rx_st;
      logic [8:0] rx_shift;
      logic [3:0] rx_cnt;
      logic [3:0] rx_sub;
      logic rx_prev;
      logic [7:0] rx_hold;
      logic [3:0] m0_div;
      logic [1:0] fix_div;
      logic t1_pre;
      logic txd;
      logic rxd_out;
      logic ap_valid;
      logic ap_write;
      logic ap_map;
      logic [7:0] ap_index;
      logic rd_wait;
      logic [31:0] hrdata;
   } port_state_t;
endpackage

// ---- verif/remote_serial.sv ----
// remote serial peer: drives the receive line and samples the device pins
`timescale 1ns/1ps
`default_nettype none
module remote_serial (
   // clock
   input wire logic hclk,
   // device pins
   input wire logic txd,
   input wire logic rxd_out,
   input wire logic rxd_oe,
   // resolved receive line
   output logic rxd_line
);
   logic peer_oe = 1'b0;
   logic peer_bit = 1'b1;
   // pull-up holds the line high when nobody drives it
   assign rxd_line = rxd_oe ? rxd_out : (peer_oe ? peer_bit : 1'b1);
   // eleven line bits, lsb first; a 10-bit frame ends in an idle bit
   task automatic send(input logic [10:0] frame, input int period);
      for (int i = 0; i < 11; i++) begin
         peer_oe <= 1'b1;
         peer_bit <= frame[i];
         repeat (period) @(posedge hclk);
      end
      peer_oe <= 1'b0;
   endtask
   // bit centres on txd after the start edge
   task automatic grab(input int period, output logic [10:0] bits, output logic ok);
      int n;
      bits = 11'h7FF;
      n = 0;
      @(posedge hclk);
      while (txd !== 1'b0 && n < 4000) begin
         @(posedge hclk);
         n++;
      end
      ok = (n < 4000);
      repeat (period / 2) @(posedge hclk);
      for (int i = 0; i < 11; i++) begin
         bits[i] = txd;
         repeat (period) @(posedge hclk);
      end
   endtask
   // shift mode: data taken on each rising shift clock, period in clocks
   task automatic grab_sync(output logic [7:0] bits, output int period, output logic ok);
      logic prev;
      int k;
      int last;
      k = 0;
      last = 0;
      period = 0;
      bits = 8'h00;
      prev = txd;
      for (int n = 0; n < 2000 && k < 8; n++) begin
         @(posedge hclk);
         if (prev === 1'b0 && txd === 1'b1) begin
            bits[k] = rxd_line;
            if (k == 1) period = n - last;
            last = n;
            k++;
         end
         prev = txd;
      end
      ok = (k == 8);
   endtask
   // shift mode receive: a new bit follows each falling shift clock, held past the last sample
   task automatic serve_sync(input logic [7:0] data, output logic ok);
      logic prev;
      int k;
      k = 0;
      prev = txd;
      for (int n = 0; n < 2000 && k < 8; n++) begin
         @(posedge hclk);
         if (prev === 1'b1 && txd === 1'b0) begin
            peer_oe <= 1'b1;
            peer_bit <= data[k];
            k++;
         end
         prev = txd;
      end
      repeat (12) @(posedge hclk);
      peer_oe <= 1'b0;
      ok = (k == 8);
   endtask
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// self-checking testbench of the four-mode serial port
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_consts.svh"
module testbench;
   import serial_port_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'b010;
   logic [31:0] hwdata = 32'h0;
   wire logic hready;
   wire logic hresp;
   wire logic [31:0] hrdata;
   baud_src_t baud_src = '0;
   wire logic txd;
   wire logic rxd_line;
   wire logic rxd_out;
   wire logic rxd_oe;
   irq_out_t irq;
   int num_errors = 0;
   int n_compared = 0;
   four_mode_serial_port four_mode_serial_port_inst (.hclk(hclk), .hresetn(hresetn), .clk_enable(1'b1),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .baud_src(baud_src),
      .txd(txd), .rxd_in(rxd_line), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .irq(irq));
   remote_serial remote_serial_inst (.hclk(hclk), .txd(txd), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
      .rxd_line(rxd_line));
   initial begin
      forever #5 hclk = ~hclk;
   end
   // timers overflow every second clock; toggling keeps each pulse one cycle wide
   always @(posedge hclk) begin
      baud_src.timer1_ovf <= ~baud_src.timer1_ovf;
      baud_src.timer2_ovf <= ~baud_src.timer2_ovf;
   end
   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wait_ready;
      int n;
      n = 0;
      @(posedge hclk);
      while (hready !== 1'b1) begin
         n++;
         if (n > 50) begin
            num_errors++;
            conclude();
         end
         @(posedge hclk);
      end
   endtask
   // one single word transfer; called just after a rising edge
   task automatic bus(input logic wr_en, input logic [7:0] idx, input logic [7:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {22'h0, idx, 2'b00};
      hwrite <= wr_en;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h0, d};
      wait_ready();
      r = hrdata;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] r;
      bus(1'b1, idx, d, r);
   endtask
   task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
      logic [31:0] r;
      bus(1'b0, idx, 8'h00, r);
      check(r, {24'h0, exp});
   endtask
   task automatic t_reset;
      rdchk(`IDX_POWER_CONTROL, `RESET_BYTE);
      rdchk(`IDX_SERIAL_CONTROL, `RESET_BYTE);
      rdchk(`IDX_SERIAL_BUFFER, `RESET_BYTE);
      rdchk(`IDX_INTERRUPT_PRIORITY, `RESET_BYTE);
      wr(8'h10, 8'hFF);
      rdchk(8'h10, 8'h00);
      check(32'(hresp), 32'h0);
      $display("test reset done");
   endtask
   // mode 1: send on the first timer while receiving on the second
   task automatic t_duplex;
      logic [10:0] bits;
      logic ok;
      baud_src.tx_timer_select <= 1'b0;
      baud_src.rx_timer_select <= 1'b1;
      wr(`IDX_SERIAL_CONTROL, 8'h50);
      fork
         remote_serial_inst.grab(64, bits, ok);
         wr(`IDX_SERIAL_BUFFER, 8'hC3);
         remote_serial_inst.send({2'b11, 8'h96, 1'b0}, 32);
      join
      check(32'(ok), 32'h1);
      check(32'(bits), {21'h0, 2'b11, 8'hC3, 1'b0});
      rdchk(`IDX_SERIAL_CONTROL, 8'h57);
      rdchk(`IDX_SERIAL_BUFFER, 8'h96);
      $display("test duplex done");
   endtask
   // mode 2 at both rates, ninth bit following the rate choice
   task automatic t_mode2;
      logic [10:0] bits;
      logic ok;
      logic [7:0] d;
      for (int k = 0; k < 2; k++) begin
         d = (k == 1) ? 8'h3C : 8'hE1;
         wr(`IDX_POWER_CONTROL, (k == 1) ? 8'h80 : 8'h00);
         wr(`IDX_SERIAL_CONTROL, (k == 1) ? 8'h88 : 8'h80);
         fork
            remote_serial_inst.grab((k == 1) ? 32 : 64, bits, ok);
            wr(`IDX_SERIAL_BUFFER, d);
         join
         check(32'(ok), 32'h1);
         check(32'(bits), {21'h0, 1'b1, 1'(k), d, 1'b0});
         rdchk(`IDX_POWER_CONTROL, (k == 1) ? 8'h80 : 8'h00);
      end
      $display("test mode 2 done");
   endtask
   // mode 3 address filtering, then data after the slave leaves the filter
   task automatic t_multi;
      wr(`IDX_SERIAL_CONTROL, 8'hF0);
      remote_serial_inst.send({2'b11, 8'h11, 1'b0} & 11'h5FF, 32);
      rdchk(`IDX_SERIAL_CONTROL, 8'hF0);
      remote_serial_inst.send({2'b11, 8'h5A, 1'b0}, 32);
      rdchk(`IDX_SERIAL_CONTROL, 8'hF5);
      rdchk(`IDX_SERIAL_BUFFER, 8'h5A);
      remote_serial_inst.send({2'b11, 8'hE7, 1'b0}, 32);
      rdchk(`IDX_SERIAL_CONTROL, 8'hF5);
      rdchk(`IDX_SERIAL_BUFFER, 8'h5A);
      wr(`IDX_SERIAL_CONTROL, 8'hD0);
      remote_serial_inst.send({2'b10, 8'h77, 1'b0}, 32);
      rdchk(`IDX_SERIAL_CONTROL, 8'hD1);
      rdchk(`IDX_SERIAL_BUFFER, 8'h77);
      wr(`IDX_SERIAL_CONTROL, 8'hC0);
      remote_serial_inst.send({2'b11, 8'h24, 1'b0}, 32);
      rdchk(`IDX_SERIAL_CONTROL, 8'hC0);
      $display("test multiprocessor done");
   endtask
   task automatic t_mode0;
      logic [7:0] b;
      int per;
      logic ok;
      wr(`IDX_SERIAL_CONTROL, 8'h00);
      fork
         remote_serial_inst.grab_sync(b, per, ok);
         wr(`IDX_SERIAL_BUFFER, 8'hA5);
      join
      check(32'(ok), 32'h1);
      check(32'(b), 32'hA5);
      check(per, 32'hC);
      // tx_done lands one half period after the last rising shift clock
      repeat (12) @(posedge hclk);
      rdchk(`IDX_SERIAL_CONTROL, 8'h02);
      fork
         remote_serial_inst.serve_sync(8'h6B, ok);
         wr(`IDX_SERIAL_CONTROL, 8'h10);
      join
      check(32'(ok), 32'h1);
      rdchk(`IDX_SERIAL_CONTROL, 8'h11);
      rdchk(`IDX_SERIAL_BUFFER, 8'h6B);
      $display("test mode 0 done");
   endtask
   task automatic t_irq;
      wr(`IDX_INTERRUPT_ENABLE, 8'h10);
      @(posedge hclk);
      check(32'(irq.request), 32'h1);
      wr(`IDX_SERIAL_CONTROL, 8'h00);
      @(posedge hclk);
      check(32'(irq.request), 32'h0);
      wr(`IDX_SERIAL_CONTROL, 8'h01);
      @(posedge hclk);
      check(32'(irq.request), 32'h1);
      wr(`IDX_INTERRUPT_ENABLE, 8'h00);
      @(posedge hclk);
      check(32'(irq.request), 32'h0);
      wr(`IDX_INTERRUPT_PRIORITY, 8'hFF);
      @(posedge hclk);
      check(32'(irq.priority_high), 32'h1);
      rdchk(`IDX_INTERRUPT_PRIORITY, 8'h3F);
      $display("test interrupt done");
   endtask
   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_duplex();
      t_mode2();
      t_multi();
      t_mode0();
      t_irq();
      conclude();
   end
endmodule
`default_nettype wire
